// *** afr_pkg.sv ***
/*
 * Package for the analog frequency reference block: units, limits,
 * defaults, selector codes and the carrier structs.
 * Assumes frequencies in 0.01 Hz units and percentages in whole percent.
 */
package afr_pkg;

  // ****************************************************************
  // Units and limits
  // ****************************************************************
  localparam int          FREQ_W          = 16;   // 0.01 Hz units
  localparam int          SAMPLE_W        = 12;   // digitised analog sample
  localparam logic [15:0] BASE_MIN_FREQ   = 16'h0bb8;  // 30.00 Hz
  localparam logic [15:0] MAX_LIMIT_FREQ  = 16'h9c40;  // 400.00 Hz
  localparam logic [15:0] BASE_RESET      = 16'h1770;  // 60.00 Hz
  localparam logic [15:0] MAX_RESET       = 16'h1770;  // 60.00 Hz
  localparam logic [15:0] MAP_FREQ_RESET  = 16'h0000;
  localparam logic [6:0]  PCT_MAX         = 7'h64;     // 100 %
  localparam logic [6:0]  START_PCT_RESET = 7'h00;
  localparam logic [6:0]  END_PCT_RESET   = 7'h64;
  localparam logic [1:0]  BELOW_START_FREQ = 2'h0;
  localparam logic [1:0]  BELOW_ZERO_RESET = 2'h1;
  localparam logic [4:0]  SMOOTH_RESET    = 5'h08;
  localparam logic [4:0]  SMOOTH_DEADBAND = 5'h1f;
  localparam logic [4:0]  SMOOTH_MAX_N    = 5'h1e;
  localparam logic [5:0]  DEADBAND_AVG_N  = 6'h10;
  localparam logic [15:0] DEADBAND_FREQ   = 16'h000a;  // 0.10 Hz

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ        = 100;
  localparam int SAMPLE_STEP_MS = 2;
  localparam int SAMPLE_CYCLES  = SAMPLE_STEP_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_MS      = 500;
  localparam int SETTLE_STEPS   = SETTLE_MS / SAMPLE_STEP_MS;

  // ****************************************************************
  // Selector codes
  // ****************************************************************
  localparam logic [1:0] SRC_VOLT_CUR = 2'h0;
  localparam logic [1:0] SRC_VOLT_POT = 2'h2;
  localparam logic [1:0] SRC_CUR_POT  = 2'h3;

  typedef struct packed {
    logic [6:0]        start_pct;
    logic [6:0]        end_pct;
    logic [FREQ_W-1:0] start_freq;
    logic [FREQ_W-1:0] end_freq;
    logic [1:0]        below_sel;
  } map_cfg_type;

  typedef struct packed {
    logic [FREQ_W-1:0] base_freq;
    logic [FREQ_W-1:0] max_freq;
  } motor_cfg_type;

endpackage

// *** window_map.sv ***
/*
 * Linear window mapping of one analog input onto a frequency range.
 * Assumes a stable configuration; one registered result per cycle.
 */
`timescale 1ns/1ps
module window_map
  import afr_pkg::*;
#(
  parameter int IN_W = SAMPLE_W
) (
  input  wire logic              clk,     // System clock
  input  wire logic              rstn,    // Sync reset, low active
  input  wire logic [IN_W-1:0]   sample,  // Analog sample
  input  wire map_cfg_type       cfg,     // Window settings
  output logic      [FREQ_W-1:0] freq     // Mapped frequency
);

  localparam logic [IN_W-1:0] FULL = {IN_W{1'b1}};

  logic [IN_W+7:0]   scaled;
  logic [IN_W+7:0]   lo;
  logic [IN_W+7:0]   hi;
  logic [FREQ_W-1:0] next_freq;
  logic [IN_W+7:0]   span;
  logic [IN_W+7:0]   pos;
  logic [FREQ_W+IN_W+8:0] prod;
  logic signed [FREQ_W+1:0] diff;

  always_comb begin
    scaled = (IN_W+8)'(sample) * (IN_W+8)'(PCT_MAX);
    lo     = (IN_W+8)'(cfg.start_pct) * (IN_W+8)'(FULL);
    hi     = (IN_W+8)'(cfg.end_pct) * (IN_W+8)'(FULL);
    span   = hi - lo;
    pos    = scaled - lo;
    diff   = $signed({2'b00, cfg.end_freq}) - $signed({2'b00, cfg.start_freq});
    prod   = '0;
    if (scaled < lo) begin
      next_freq = (cfg.below_sel == BELOW_START_FREQ) ? cfg.start_freq
                                                      : '0;
    end else if (scaled >= hi || span == '0) begin
      next_freq = cfg.end_freq;
    end else begin
      // Magnitude of slope times offset, sign applied after division
      prod = (FREQ_W+IN_W+9)'(diff[FREQ_W+1] ? -diff : diff)
             * (FREQ_W+IN_W+9)'(pos);
      prod = prod / (FREQ_W+IN_W+9)'(span);
      next_freq = diff[FREQ_W+1] ? cfg.start_freq - prod[FREQ_W-1:0]
                                 : cfg.start_freq + prod[FREQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      freq <= '0;
    end else begin
      freq <= next_freq;
    end
  end

endmodule

// *** analog_freq_reference.sv ***
/*
 * Analog frequency reference: input selection, window mapping,
 * smoothing, base/max clamping and a V/f voltage command.
 * Assumes analog samples arrive from another domain (synchronised here)
 * and settings change only while the drive is stopped.
 */
// Function
// - Base frequency kept between 30 Hz and max frequency, reset 60.0 Hz.
// - Max frequency kept between 30 Hz and 400 Hz; output never above it.
// - Voltage rises with frequency to full scale at base, then holds.
// - Second base/max set for alternate motor; selected set is used.
// - Separate voltage and current-loop inputs, each with own scaling.
// - Voltage window start/end percent 0..100, reset 0 and 100.
// - Start and end frequencies settable 0 to 400.0, reset zero.
// - Below start: start frequency for code 00, 0 Hz for code 01.
// - Above end point the end frequency is held.
// - Current-loop input uses the same mapping with its own settings.
// - Selector 00 volt/current, 02 volt/pot, 03 current/pot by terminal.
// - Without an input-select terminal, voltage plus current is used.
// - Settings 1..30: moving average of n samples, 2 ms steps, reset 8.
// - Setting 31: 500 ms settle, then 16-sample averages with deadband.
// - Average outside 0.1 Hz band is applied and becomes comparison point.
`timescale 1ns/1ps
module analog_freq_reference
  import afr_pkg::*;
#(
  parameter int STEP_CYCLES = SAMPLE_CYCLES
) (
  input  wire logic                clk,                   // System clock
  input  wire logic                rstn,                  // Sync reset, low
  input  wire logic [SAMPLE_W-1:0] voltage_input,         // Voltage sample
  input  wire logic [SAMPLE_W-1:0] current_loop_input,    // Current sample
  input  wire logic [SAMPLE_W-1:0] external_pot_input,    // Pot sample
  input  wire logic                input_select_terminal, // Select pin
  input  wire logic                select_assigned,       // Terminal in use
  input  wire logic [1:0]          analog_source_select,  // Selector code
  input  wire map_cfg_type         voltage_cfg,           // Voltage window
  input  wire map_cfg_type         current_cfg,           // Current window
  input  wire map_cfg_type         pot_cfg,               // Pot window
  input  wire logic [4:0]          input_smoothing_select, // Filter n
  input  wire motor_cfg_type       motor1_cfg,            // First motor
  input  wire motor_cfg_type       motor2_cfg,            // Alternate motor
  input  wire logic                second_motor,          // Use alternate
  output logic [FREQ_W-1:0]        freq_reference,        // Final frequency
  output logic [FREQ_W-1:0]        max_output_frequency,  // Active max
  output logic [FREQ_W-1:0]        base_frequency,        // Active base
  output logic [15:0]              voltage_command        // V/f, ffff full
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SAMPLE_W-1:0] v_meta, v_sync, c_meta, c_sync, p_meta, p_sync;
  logic [SAMPLE_W-1:0] v_last, c_last, p_last, v_word, c_word, p_word;
  logic                t_meta, t_sync;

  // Words cross bit by bit, so one is taken only once it held a cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      v_meta <= '0; v_sync <= '0; c_meta <= '0; c_sync <= '0;
      p_meta <= '0; p_sync <= '0; t_meta <= 1'b0; t_sync <= 1'b0;
      v_last <= '0; c_last <= '0; p_last <= '0;
      v_word <= '0; c_word <= '0; p_word <= '0;
    end else begin
      v_meta <= voltage_input;      v_sync <= v_meta;
      c_meta <= current_loop_input; c_sync <= c_meta;
      p_meta <= external_pot_input; p_sync <= p_meta;
      t_meta <= input_select_terminal; t_sync <= t_meta;
      v_last <= v_sync; c_last <= c_sync; p_last <= p_sync;
      if (v_sync == v_last) v_word <= v_sync;
      if (c_sync == c_last) c_word <= c_sync;
      if (p_sync == p_last) p_word <= p_sync;
    end
  end

  // ****************************************************************
  // Settings clamp
  // ****************************************************************
  map_cfg_type   v_cfg, c_cfg, p_cfg;
  motor_cfg_type mcfg;
  logic [FREQ_W-1:0] next_max, next_base;

  function automatic map_cfg_type clamp_map(input map_cfg_type c);
    map_cfg_type r;
    r = c;
    if (r.start_pct > PCT_MAX) r.start_pct = PCT_MAX;
    if (r.end_pct > PCT_MAX) r.end_pct = PCT_MAX;
    if (r.start_freq > MAX_LIMIT_FREQ) r.start_freq = MAX_LIMIT_FREQ;
    if (r.end_freq > MAX_LIMIT_FREQ) r.end_freq = MAX_LIMIT_FREQ;
    return r;
  endfunction

  always_comb begin
    v_cfg = clamp_map(voltage_cfg);
    c_cfg = clamp_map(current_cfg);
    p_cfg = clamp_map(pot_cfg);
    mcfg  = second_motor ? motor2_cfg : motor1_cfg;
    next_max = mcfg.max_freq;
    if (next_max > MAX_LIMIT_FREQ) next_max = MAX_LIMIT_FREQ;
    if (next_max < BASE_MIN_FREQ) next_max = BASE_MIN_FREQ;
    next_base = mcfg.base_freq;
    if (next_base < BASE_MIN_FREQ) next_base = BASE_MIN_FREQ;
    if (next_base > next_max) next_base = next_max;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      max_output_frequency <= MAX_RESET;
      base_frequency       <= BASE_RESET;
    end else begin
      max_output_frequency <= next_max;
      base_frequency       <= next_base;
    end
  end

  // ****************************************************************
  // Mapping and source selection
  // ****************************************************************
  logic [FREQ_W-1:0] v_freq, c_freq, p_freq, next_sel;
  logic [FREQ_W:0]   sum_freq;

  window_map #(.IN_W(SAMPLE_W)) u_map_v (
    .clk(clk), .rstn(rstn), .sample(v_word), .cfg(v_cfg), .freq(v_freq));
  window_map #(.IN_W(SAMPLE_W)) u_map_c (
    .clk(clk), .rstn(rstn), .sample(c_word), .cfg(c_cfg), .freq(c_freq));
  window_map #(.IN_W(SAMPLE_W)) u_map_p (
    .clk(clk), .rstn(rstn), .sample(p_word), .cfg(p_cfg), .freq(p_freq));

  always_comb begin
    sum_freq = {1'b0, v_freq} + {1'b0, c_freq};
    if (!select_assigned) begin
      // Saturate so the sum never wraps to a low speed
      next_sel = sum_freq[FREQ_W] ? {FREQ_W{1'b1}}
                                  : sum_freq[FREQ_W-1:0];
    end else begin
      unique case (analog_source_select)
        SRC_VOLT_POT: next_sel = t_sync ? p_freq : v_freq;
        SRC_CUR_POT:  next_sel = t_sync ? p_freq : c_freq;
        default:      next_sel = t_sync ? c_freq : v_freq;
      endcase
    end
  end

  // ****************************************************************
  // Smoothing, one sample per 2 ms step
  // ****************************************************************
  localparam int HIST = 32;
  logic [31:0]       step_cnt;
  logic              step;
  logic [FREQ_W-1:0] hist [HIST];
  logic [4:0]        wr_ptr;
  logic [FREQ_W+5:0] avg_sum;
  logic [5:0]        n_len;
  logic [7:0]        settle_cnt;
  logic [FREQ_W-1:0] avg, hold_point;
  logic              deadband;

  assign deadband = (input_smoothing_select == SMOOTH_DEADBAND);
  assign step     = (step_cnt == 32'(STEP_CYCLES - 1));

  always_comb begin
    n_len = deadband ? DEADBAND_AVG_N :
            (input_smoothing_select == 5'h00) ? 6'h01 :
            (input_smoothing_select > SMOOTH_MAX_N) ? 6'(SMOOTH_MAX_N) :
            6'(input_smoothing_select);
    avg_sum = '0;
    for (int i = 0; i < HIST; i++) begin
      if (6'(i) < n_len) begin
        avg_sum = avg_sum + (FREQ_W+6)'(hist[5'(wr_ptr - 5'(i) - 5'h01)]);
      end
    end
    avg = FREQ_W'(avg_sum / (FREQ_W+6)'(n_len));
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step ? '0 : step_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      for (int i = 0; i < HIST; i++) hist[i] <= '0;
    end else if (step) begin
      hist[wr_ptr] <= next_sel;
      wr_ptr       <= wr_ptr + 5'h01;
    end
  end

  // Settle phase lets the long average fill before the band is held
  always_ff @(posedge clk) begin
    if (!rstn || !deadband) begin
      settle_cnt <= '0;
      hold_point <= '0;
    end else if (step) begin
      if (settle_cnt < 8'(SETTLE_STEPS)) begin
        settle_cnt <= settle_cnt + 8'h01;
        hold_point <= avg;
      end else if (avg > hold_point + DEADBAND_FREQ ||
                   hold_point > avg + DEADBAND_FREQ) begin
        hold_point <= avg;
      end
    end
  end

  // ****************************************************************
  // Output clamp and V/f
  // ****************************************************************
  logic [FREQ_W-1:0] filt;
  logic [31:0]       vf;
  assign filt = deadband ? hold_point : avg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      freq_reference <= '0;
    end else begin
      freq_reference <= (filt > max_output_frequency) ? max_output_frequency
                                                      : filt;
    end
  end

  always_comb begin
    vf = (32'(freq_reference) * 32'hffff) / 32'(base_frequency);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      voltage_command <= '0;
    end else begin
      voltage_command <= (freq_reference >= base_frequency) ? 16'hffff
                                                            : vf[15:0];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ref_below_max: assert property (
    @(posedge clk) disable iff (!rstn)
    ##1 freq_reference <= $past(max_output_frequency))
    else $error("frequency reference above maximum");
  a_base_in_range: assert property (
    @(posedge clk) disable iff (!rstn)
    base_frequency >= BASE_MIN_FREQ &&
    base_frequency <= max_output_frequency)
    else $error("base frequency out of range");
  a_max_limit: assert property (
    @(posedge clk) disable iff (!rstn)
    max_output_frequency <= MAX_LIMIT_FREQ)
    else $error("maximum above 400 Hz");
  a_volt_full_scale: assert property (
    @(posedge clk) disable iff (!rstn)
    freq_reference >= base_frequency |=> voltage_command == 16'hffff)
    else $error("voltage not full above base");
  a_motor_set_used: assert property (
    @(posedge clk) disable iff (!rstn)
    $stable(second_motor) && $stable(motor2_cfg) && second_motor &&
    motor2_cfg.max_freq >= BASE_MIN_FREQ &&
    motor2_cfg.max_freq <= MAX_LIMIT_FREQ
    |=> max_output_frequency == motor2_cfg.max_freq)
    else $error("alternate maximum not applied");
  a_deadband_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    deadband && settle_cnt == 8'(SETTLE_STEPS) && step &&
    avg <= hold_point + DEADBAND_FREQ && hold_point <= avg + DEADBAND_FREQ
    && $past(deadband) |=> $stable(hold_point))
    else $error("deadband point moved inside band");
  a_sum_select: assert property (
    @(posedge clk) disable iff (!rstn)
    !select_assigned && !sum_freq[FREQ_W]
    |-> next_sel == v_freq + c_freq)
    else $error("sum of inputs not used");
  a_pot_select: assert property (
    @(posedge clk) disable iff (!rstn)
    select_assigned && analog_source_select == SRC_CUR_POT && !t_sync
    |-> next_sel == c_freq)
    else $error("current input not selected");
  c_deadband: cover property (@(posedge clk) deadband && step &&
    settle_cnt == 8'(SETTLE_STEPS));
  c_second: cover property (@(posedge clk) second_motor);
  c_limit: cover property (@(posedge clk)
    filt > max_output_frequency);

endmodule

// *** analog_source_model.sv ***
/*
 * Behavioural model of the analog front end: converts commanded levels
 * into digitised samples after a short conversion delay.
 * Assumes the bench commands levels just after a rising clock edge.
 */
`timescale 1ns/1ps
module analog_source_model
  import afr_pkg::*;
(
  input  wire logic                clk,          // System clock
  input  wire logic [SAMPLE_W-1:0] volt_level,   // Commanded voltage
  input  wire logic [SAMPLE_W-1:0] cur_level,    // Commanded current
  input  wire logic [SAMPLE_W-1:0] pot_level,    // Commanded pot position
  input  wire logic                sel_level,    // Commanded select pin
  output logic      [SAMPLE_W-1:0] volt_sample,  // Voltage sample
  output logic      [SAMPLE_W-1:0] cur_sample,   // Current sample
  output logic      [SAMPLE_W-1:0] pot_sample,   // Pot sample
  output logic                     sel_pin       // Select pin level
);
  // ****************************************************************
  // Conversion pipeline
  // ****************************************************************
  // Two stages, so the block never sees a level in the cycle it is set
  logic [3*SAMPLE_W:0] stage;

  always_ff @(posedge clk) begin
    stage <= {volt_level, cur_level, pot_level, sel_level};
    {volt_sample, cur_sample, pot_sample, sel_pin} <= stage;
  end
endmodule

// *** analog_freq_reference_test.sv ***
/*
 * Self-checking bench for the analog frequency reference block.
 * Assumes afr_pkg and the analog source model; short sample step.
 */
`timescale 1ns/1ps
module analog_freq_reference_test
  import afr_pkg::*;
;
  localparam int STEP  = 8;
  localparam int LIMIT = 12000;
  logic clk, rstn, sel_level, select_assigned, second_motor;
  logic [SAMPLE_W-1:0] volt_level, cur_level, pot_level;
  logic [SAMPLE_W-1:0] voltage_input, current_loop_input, external_pot_input;
  logic                input_select_terminal;
  logic [1:0]          analog_source_select;
  map_cfg_type         voltage_cfg, current_cfg, pot_cfg;
  logic [4:0]          input_smoothing_select;
  motor_cfg_type       motor1_cfg, motor2_cfg;
  logic [FREQ_W-1:0]   freq_reference, max_output_frequency, base_frequency;
  logic [15:0]         voltage_command;
  int                  miscompares, n_checks, cycles;

  analog_source_model src (.clk(clk), .volt_level(volt_level),
    .cur_level(cur_level), .pot_level(pot_level), .sel_level(sel_level),
    .volt_sample(voltage_input), .cur_sample(current_loop_input),
    .pot_sample(external_pot_input), .sel_pin(input_select_terminal));

  analog_freq_reference #(.STEP_CYCLES(STEP)) uut (.clk(clk), .rstn(rstn),
    .voltage_input(voltage_input), .current_loop_input(current_loop_input),
    .external_pot_input(external_pot_input),
    .input_select_terminal(input_select_terminal),
    .select_assigned(select_assigned),
    .analog_source_select(analog_source_select),
    .voltage_cfg(voltage_cfg), .current_cfg(current_cfg), .pot_cfg(pot_cfg),
    .input_smoothing_select(input_smoothing_select),
    .motor1_cfg(motor1_cfg), .motor2_cfg(motor2_cfg),
    .second_motor(second_motor), .freq_reference(freq_reference),
    .max_output_frequency(max_output_frequency),
    .base_frequency(base_frequency), .voltage_command(voltage_command));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic map_cfg_type mk(input logic [6:0] sp, ep,
                                     input logic [15:0] sf, ef,
                                     input logic [1:0] bs);
    mk = '{sp, ep, sf, ef, bs};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Interpolated values tolerate rounding of the scaled fraction
  task automatic near(input logic [15:0] seen, exp, tol);
    if (seen >= exp - tol && seen <= exp + tol)
      check(exp, exp);
    else
      check(seen, exp);
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_clamp;
    motor1_cfg = '{16'h03e8, 16'hc350};
    step(5);
    check(base_frequency, 16'h0bb8);
    check(max_output_frequency, 16'h9c40);
    motor1_cfg = '{16'h2710, 16'h1770};
    step(5);
    check(base_frequency, 16'h1770);
    motor1_cfg = '{16'h0bb8, 16'h0fa0};
    voltage_cfg.end_freq = 16'h1388;
    step(40);
    check(freq_reference, 16'h0fa0);
    second_motor = 1'b1;
    step(5);
    check(base_frequency, 16'h1770);
    check(max_output_frequency, 16'h1f40);
    check(freq_reference, 16'h1388);
    second_motor = 1'b0;
    motor1_cfg = '{16'h0bb8, 16'h9c40};
    voltage_cfg.end_freq = 16'h07d0;
  endtask

  task automatic t_window;
    voltage_cfg = mk(7'h14, 7'h50, 16'h03e8, 16'h1388, 2'h1);
    volt_level = 12'h000;
    step(40);
    check(freq_reference, 16'h0000);
    voltage_cfg.below_sel = 2'h0;
    step(40);
    check(freq_reference, 16'h03e8);
    volt_level = 12'h7ff;
    step(40);
    near(freq_reference, 16'h0bb8, 16'h0014);
    volt_level = 12'hfff;
    step(40);
    check(freq_reference, 16'h1388);
    voltage_cfg.end_freq = 16'h9c40;
    step(40);
    check(freq_reference, 16'h9c40);
    voltage_cfg = mk(7'h00, 7'h7f, 16'h0000, 16'hc350, 2'h1);
    step(40);
    check(freq_reference, 16'h9c40);
    volt_level = 12'h7ff;
    step(40);
    near(freq_reference, 16'h4e20, 16'h0014);
    volt_level = 12'hfff;
    voltage_cfg = mk(7'h00, 7'h64, 16'h0000, 16'h07d0, 2'h1);
  endtask

  task automatic t_select;
    logic [1:0]  code [6] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3};
    logic [15:0] exp  [6] = '{16'h07d0, 16'h0bb8, 16'h07d0, 16'h0fa0,
                              16'h0bb8, 16'h0fa0};
    for (int i = 0; i < 6; i++) begin
      analog_source_select = code[i];
      sel_level = i[0];
      step(40);
      check(freq_reference, exp[i]);
    end
    analog_source_select = 2'h1;
    current_cfg = mk(7'h14, 7'h50, 16'h03e8, 16'h1388, 2'h0);
    cur_level = 12'h000;
    step(40);
    check(freq_reference, 16'h03e8);
    current_cfg = mk(7'h00, 7'h64, 16'h0000, 16'h0bb8, 2'h1);
    cur_level = 12'hfff;
    sel_level = 1'b0;
    select_assigned = 1'b0;
    step(40);
    check(freq_reference, 16'h1388);
    select_assigned = 1'b1;
    step(40);
    check(freq_reference, 16'h07d0);
    analog_source_select = 2'h0;
  endtask

  task automatic t_vf;
    voltage_cfg.end_freq = 16'h0fa0;
    step(40);
    check(voltage_command, 16'hffff);
    voltage_cfg.end_freq = 16'h05dc;
    step(40);
    near(voltage_command, 16'h7fff, 16'h0100);
    voltage_cfg.end_freq = 16'h07d0;
  endtask

  task automatic t_average;
    int changes;
    int t0;
    logic [15:0] last;
    input_smoothing_select = 5'h04;
    step(60);
    changes = 0;
    t0 = 0;
    last = freq_reference;
    volt_level = 12'h000;
    for (int i = 0; i < 100; i++) begin
      step(1);
      if (freq_reference !== last) begin
        changes++;
        last = freq_reference;
        check(16'(last % 16'h01f4), 16'h0000);
        if (changes > 1) check(16'(cycles - t0), 16'(STEP));
        t0 = cycles;
      end
    end
    check(16'(changes), 16'h0004);
    check(freq_reference, 16'h0000);
    volt_level = 12'hfff;
  endtask

  task automatic t_deadband;
    input_smoothing_select = SMOOTH_DEADBAND;
    step((SETTLE_STEPS + 40) * STEP);
    check(freq_reference, 16'h07d0);
    voltage_cfg.end_freq = 16'h07da;
    step(40 * STEP);
    check(freq_reference, 16'h07d0);
    // Steps of the average exceed the band, so the point tracks to the end
    voltage_cfg.end_freq = 16'h09da;
    step(40 * STEP);
    check(freq_reference, 16'h09da);
  endtask

  task automatic t_reset;
    rstn = 1'b0;
    step(2);
    check(freq_reference, 16'h0000);
    check(voltage_command, 16'h0000);
    check(base_frequency, BASE_RESET);
    check(max_output_frequency, MAX_RESET);
    rstn = 1'b1;
    step(2);
    check(max_output_frequency, 16'h9c40);
  endtask

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs about 3920 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      end_of_test;
    end
  end

  initial begin
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    rstn = 1'b0;
    {volt_level, cur_level, pot_level} = {3{12'hfff}};
    sel_level = 1'b0;
    select_assigned = 1'b1;
    second_motor = 1'b0;
    analog_source_select = 2'h0;
    voltage_cfg = mk(7'h00, 7'h64, 16'h0000, 16'h07d0, 2'h1);
    current_cfg = mk(7'h00, 7'h64, 16'h0000, 16'h0bb8, 2'h1);
    pot_cfg = mk(7'h00, 7'h64, 16'h0000, 16'h0fa0, 2'h1);
    input_smoothing_select = 5'h01;
    motor1_cfg = '{16'h0bb8, 16'h9c40};
    motor2_cfg = '{16'h1770, 16'h1f40};
    step(19);
    check(base_frequency, BASE_RESET);
    check(max_output_frequency, MAX_RESET);
    check(freq_reference, 16'h0000);
    check(voltage_command, 16'h0000);
    step(1);
    rstn = 1'b1;
    t_clamp();
    t_window();
    t_select();
    t_vf();
    t_average();
    t_deadband();
    t_reset();
    end_of_test();
  end
endmodule
